// ===== hdl/rfa_pkg.sv
// constants and types shared by the receiver fifo, sync and frequency correction block
package rfa_pkg;
    // command selectors: the upper byte of a 16-bit command word, and the whole 16-bit read word
    localparam logic [7:0] CMD_FIFO = 8'hCA;
    localparam logic [7:0] CMD_SYNC = 8'hCE;
    localparam logic [7:0] CMD_FREQ = 8'hC4;
    localparam logic [7:0] CMD_READ_HI = 8'hB0;
    localparam logic [15:0] CMD_READ = 16'hB000;
    // values after reset, and the fixed high sync byte
    localparam logic [15:0] POR_FIFO = 16'hCA80;
    localparam logic [15:0] POR_SYNC = 16'hCED4;
    localparam logic [15:0] POR_FREQ = 16'hC4F7;
    localparam logic [7:0] SYNC_HI_BYTE = 8'h2D;
    // fifo and reset mode fields
    localparam int IRQ_LVL_LSB = 4;
    localparam int SYNC_LEN_BIT = 3;
    localparam int FILL_ALWAYS_BIT = 2;
    localparam int FILL_EN_BIT = 1;
    localparam int RST_SENS_BIT = 0;
    // frequency correction fields
    localparam int MODE_LSB = 6;
    localparam int RANGE_LSB = 4;
    localparam int STROBE_BIT = 3;
    localparam int FINE_BIT = 2;
    localparam int OFS_EN_BIT = 1;
    localparam int CALC_EN_BIT = 0;
    // offset register width and range limits, two's complement
    localparam int OFS_W = 8;
    localparam logic signed [7:0] LIM0_HI = 8'h7F;
    localparam logic signed [7:0] LIM0_LO = 8'h80;
    localparam logic signed [7:0] LIM1_HI = 8'h0F;
    localparam logic signed [7:0] LIM1_LO = 8'hF0;
    localparam logic signed [7:0] LIM2_HI = 8'h07;
    localparam logic signed [7:0] LIM2_LO = 8'hF8;
    localparam logic signed [7:0] LIM3_HI = 8'h03;
    localparam logic signed [7:0] LIM3_LO = 8'hFC;
    // timing and sizes
    localparam int CLK_PERIOD_NS = 20;
    localparam int MEAS_TIME_NS = 1280;
    localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int QUEUE_BITS = 16;
    localparam int BYTE_BITS = 8;
    // correction modes and valid-data response settings
    typedef enum logic [1:0] {MODE_MANUAL, MODE_ONCE, MODE_DROP, MODE_KEEP} rfa_mode_t;
    typedef enum logic [1:0] {VDI_FAST, VDI_MEDIUM, VDI_SLOW, VDI_ALWAYS} rfa_vdi_t;
endpackage

// ===== hdl/rfa_link_if.sv
// carrier between the serial link logic and the core
`timescale 1ns/1ps
interface rfa_link_if;
    logic [15:0] cmdWord;
    logic cmdToggle;
    logic [7:0] readByte;
    modport link (output cmdWord, output cmdToggle, input readByte);
    modport core (input cmdWord, input cmdToggle, output readByte);
endinterface

// ===== hdl/rfa_serial_link.sv
// serial command shifter on the link clock
`timescale 1ns/1ps
module rfa_serial_link
    import rfa_pkg::*;
(
    // link clock, frame and data
    input wire logic sck,
    input wire logic srst,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    // words to the core
    rfa_link_if.link lnk
);
    logic [3:0] bitCnt_r;
    logic [14:0] shift_r;
    logic readSel_r;

    // chip select high clears the count with no edge, since the link clock stops between frames
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            bitCnt_r <= 4'h0;
            readSel_r <= 1'b0;
        end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'h7) begin
                readSel_r <= ({shift_r[6:0], sdi} == CMD_READ_HI);
            end
        end
    end

    // msb first shifting
    always_ff @(posedge sck) begin
        shift_r <= {shift_r[13:0], sdi};
    end

    // complete word is held and announced by a toggle until the next sixteenth bit
    always_ff @(posedge sck or posedge srst) begin
        if (srst) begin
            lnk.cmdWord <= 16'h0000;
            lnk.cmdToggle <= 1'b0;
        end else if (!csN && bitCnt_r == 4'hF) begin
            lnk.cmdWord <= {shift_r, sdi};
            lnk.cmdToggle <= ~lnk.cmdToggle;
        end
    end

    // read data changes on the falling edge so the host samples it on the rising one
    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            sdo <= 1'b0;
        end else if (readSel_r && bitCnt_r[3]) begin
            sdo <= lnk.readByte[~bitCnt_r[2:0]];
        end else begin
            sdo <= 1'b0;
        end
    end
endmodule // rfa_serial_link

// ===== hdl/rfa_bit_queue.sv
// bit-wide receive queue, read out a byte at a time
`timescale 1ns/1ps
module rfa_bit_queue
    import rfa_pkg::*;
#(
    parameter int DEPTH = QUEUE_BITS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // fill and drain
    input wire logic wrBit,
    input wire logic wrEn,
    input wire logic popByte,
    output logic [$clog2(DEPTH):0] count,
    output logic [7:0] headByte
);
    localparam int AW = $clog2(DEPTH);
    logic [DEPTH-1:0] bits_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW-1:0] wrPtr_r;
    logic doWr;
    logic doPop;

    if (DEPTH < BYTE_BITS || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("queue depth must be a power of two of at least one byte");
    end

    // a full queue drops new bits; a partial byte is never removed
    assign doWr = wrEn && (count != (AW+1)'(DEPTH));
    assign doPop = popByte && (count >= (AW+1)'(BYTE_BITS));

    // pointers and stored bit count
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdPtr_r <= '0;
            wrPtr_r <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                bits_r[wrPtr_r] <= wrBit;
                wrPtr_r <= wrPtr_r + AW'(1);
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + AW'(BYTE_BITS);
            end
            count <= count + (AW+1)'(doWr) - (doPop ? (AW+1)'(BYTE_BITS) : '0);
        end
    end

    // oldest bit goes out first as the msb; missing bits read as zero
    for (genvar i = 0; i < BYTE_BITS; i++) begin : g_head
        assign headByte[BYTE_BITS-1-i] = (count > (AW+1)'(i)) ?
            bits_r[AW'(rdPtr_r + AW'(i))] : 1'b0;
    end
endmodule // rfa_bit_queue

// ===== hdl/rfa_rx_sync_afc_ctrl.sv
// receiver back end: command decode, sync search, fifo fill, valid data and frequency correction
// Overview of operation
// - command with upper byte CAh loads fifo/reset config; resets to CA80h
// - interrupt request once stored bit count reaches the 4-bit level in bits 7..4
// - sync word is 2DD4h, or only D4h when the length bit is set
// - high sync byte fixed at 2Dh; only the low byte is programmable
// - fill-start bit clear waits for sync; set fills unconditionally
// - fill only while fill-enable is set; clearing it stops fill at once
// - bit 0 selects sensitive or non-sensitive reset mode
// - sync command replaces the low sync byte; resets to CED4h
// - read command B000h shifts out one byte; host uses it only when queue enabled
// - 2-bit mode: manual strobe, once, drop with valid-data, keep; resets C4F7h
// - 2-bit range field clamps offset: none, +15/-16, +7/-8, +3/-4
// - in manual mode, a strobe rising edge copies latest frequency error into the offset
// - fine bit doubles measurement time for half uncertainty
// - offset reaches the synthesizer word only while offset-enable is set
// - frequency offset is measured only while calculation-enable is set
// - a status bit toggles at the end of each measurement cycle
// - automatic update needs valid-data all cycle and two equal results
// - drop mode clears the offset when valid-data falls
// - valid-data derived per response setting: fast, medium, slow, always
`timescale 1ns/1ps
module rfa_rx_sync_afc_ctrl
    import rfa_pkg::*;
#(
    parameter int MEAS_LEN = MEAS_CYCLES,
    parameter int DEPTH = QUEUE_BITS
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic srst,
    // serial command link
    input wire logic sck,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    // demodulated receive stream
    input wire logic rxBit,
    input wire logic rxBitValid,
    // receiver flags and settings
    input wire logic dataQualityFlag,
    input wire logic rssiFlag,
    input wire logic crLockFlag,
    input wire logic [1:0] vdiResponse,
    input wire logic queueEnable,
    // frequency error from the demodulator
    input wire logic signed [OFS_W-1:0] freqError,
    // status and results
    output logic irqRequest,
    output logic validDataFlag,
    output logic measureToggle,
    output logic resetSensitivityOff,
    output logic fineMeasure,
    output logic signed [OFS_W-1:0] offsetWord
);
    localparam int MW = $clog2(2 * MEAS_LEN + 1);
    localparam int CW = $clog2(DEPTH) + 1;

    if (MEAS_LEN < 2) begin : g_bad_meas
        $error("measurement length must be at least two cycles");
    end

    rfa_link_if lnk ();
    logic [2:0] tgSync_r;
    logic [2:0] csSync_r;
    logic tgSeen_r;
    logic newWord;
    logic [15:0] fifoCfg_r;
    logic [15:0] syncCfg_r;
    logic [15:0] freqCfg_r;
    logic popReq_r;
    logic [3:0] irqLevel;
    logic syncLen;
    logic fillAlways;
    logic fillEnable;
    logic [15:0] rxShift_r;
    logic [15:0] rxShiftNxt;
    logic syncMatch;
    logic fillActive_r;
    logic [CW-1:0] bitCount;
    logic [7:0] headByte;
    logic slowHold_r;
    logic vdiPrev_r;
    rfa_mode_t mode;
    logic [1:0] rangeSel;
    logic strobe;
    logic strobePrev_r;
    logic ofsEnable;
    logic calcEnable;
    logic [MW-1:0] measCnt_r;
    logic [MW-1:0] measLimit;
    logic measDone_r;
    logic vdiAll_r;
    logic vdiWhole_r;
    logic sameTwice_r;
    logic signed [OFS_W-1:0] latestErr_r;
    logic signed [OFS_W-1:0] offset_r;
    logic onceDone_r;
    logic autoOk;

    // clamp to the selected range
    function automatic logic signed [OFS_W-1:0] clampOfs(
        input logic signed [OFS_W-1:0] v,
        input logic [1:0] rng
    );
        logic signed [OFS_W-1:0] hi;
        logic signed [OFS_W-1:0] lo;
        hi = LIM0_HI;
        lo = LIM0_LO;
        case (rng)
            2'h1: begin
                hi = LIM1_HI;
                lo = LIM1_LO;
            end
            2'h2: begin
                hi = LIM2_HI;
                lo = LIM2_LO;
            end
            2'h3: begin
                hi = LIM3_HI;
                lo = LIM3_LO;
            end
            default: ;
        endcase
        return (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    rfa_serial_link u_link (
        .sck(sck),
        .srst(srst),
        .csN(csN),
        .sdi(sdi),
        .sdo(sdo),
        .lnk(lnk)
    );

    // link events cross by toggle, chip select by level; first stages feed only second stages
    always_ff @(posedge mclk) begin
        if (srst) begin
            tgSync_r <= 3'h0;
            csSync_r <= 3'h7;
            tgSeen_r <= 1'b0;
        end else begin
            tgSync_r <= {tgSync_r[1:0], lnk.cmdToggle};
            csSync_r <= {csSync_r[1:0], csN};
            if (tgSync_r[2] == tgSync_r[1]) begin
                tgSeen_r <= tgSync_r[2];
            end
        end
    end
    assign newWord = (tgSync_r[2] == tgSync_r[1]) && (tgSync_r[2] != tgSeen_r);

    // command decode: the word is stable for many mclk cycles after its toggle
    always_ff @(posedge mclk) begin
        if (srst) begin
            fifoCfg_r <= POR_FIFO;
            syncCfg_r <= POR_SYNC;
            freqCfg_r <= POR_FREQ;
        end else if (newWord) begin
            case (lnk.cmdWord[15:8])
                CMD_FIFO: fifoCfg_r <= lnk.cmdWord;
                CMD_SYNC: syncCfg_r <= lnk.cmdWord;
                CMD_FREQ: freqCfg_r <= lnk.cmdWord;
                default: ;
            endcase
        end
    end

    // a read is ignored while the queue is disabled
    always_ff @(posedge mclk) begin
        if (srst) begin
            popReq_r <= 1'b0;
        end else begin
            popReq_r <= newWord && (lnk.cmdWord == CMD_READ) && queueEnable;
        end
    end

    // field views
    assign irqLevel = fifoCfg_r[IRQ_LVL_LSB +: 4];
    assign syncLen = fifoCfg_r[SYNC_LEN_BIT];
    assign fillAlways = fifoCfg_r[FILL_ALWAYS_BIT];
    assign fillEnable = fifoCfg_r[FILL_EN_BIT];
    assign resetSensitivityOff = fifoCfg_r[RST_SENS_BIT];
    assign mode = rfa_mode_t'(freqCfg_r[MODE_LSB +: 2]);
    assign rangeSel = freqCfg_r[RANGE_LSB +: 2];
    assign strobe = freqCfg_r[STROBE_BIT];
    assign fineMeasure = freqCfg_r[FINE_BIT];
    assign ofsEnable = freqCfg_r[OFS_EN_BIT];
    assign calcEnable = freqCfg_r[CALC_EN_BIT];

    // slow response needs all three to rise and all three gone to fall
    always_ff @(posedge mclk) begin
        if (srst) begin
            slowHold_r <= 1'b0;
        end else if (dataQualityFlag && rssiFlag && crLockFlag) begin
            slowHold_r <= 1'b1;
        end else if (!dataQualityFlag && !rssiFlag && !crLockFlag) begin
            slowHold_r <= 1'b0;
        end
    end

    // valid-data indicator by response setting
    always_ff @(posedge mclk) begin
        if (srst) begin
            validDataFlag <= 1'b0;
            vdiPrev_r <= 1'b0;
        end else begin
            vdiPrev_r <= validDataFlag;
            case (rfa_vdi_t'(vdiResponse))
                VDI_FAST: validDataFlag <= dataQualityFlag;
                VDI_MEDIUM: validDataFlag <= crLockFlag && (rssiFlag || dataQualityFlag);
                VDI_SLOW: validDataFlag <= slowHold_r;
                default: validDataFlag <= 1'b1;
            endcase
        end
    end

    // sync search sees the bit being shifted in; the pattern bits are not stored
    assign rxShiftNxt = {rxShift_r[14:0], rxBit};
    assign syncMatch = syncLen ? (rxShiftNxt[7:0] == syncCfg_r[7:0]) :
        (rxShiftNxt == {SYNC_HI_BYTE, syncCfg_r[7:0]});

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxShift_r <= 16'h0000;
        end else if (rxBitValid) begin
            rxShift_r <= rxShiftNxt;
        end
    end

    // fill gate; clearing the enable stops fill and rearms the search
    always_ff @(posedge mclk) begin
        if (srst) begin
            fillActive_r <= 1'b0;
        end else if (!fillEnable) begin
            fillActive_r <= 1'b0;
        end else if (fillAlways) begin
            fillActive_r <= 1'b1;
        end else if (rxBitValid && syncMatch) begin
            fillActive_r <= 1'b1;
        end
    end

    rfa_bit_queue #(
        .DEPTH(DEPTH)
    ) u_queue (
        .mclk(mclk),
        .srst(srst),
        .wrBit(rxBit),
        .wrEn(rxBitValid && fillActive_r && fillEnable),
        .popByte(popReq_r),
        .count(bitCount),
        .headByte(headByte)
    );

    // read byte only moves between frames so the link never sees it change mid-shift
    always_ff @(posedge mclk) begin
        if (srst) begin
            lnk.readByte <= 8'h00;
        end else if (csSync_r[2] && csSync_r[1]) begin
            lnk.readByte <= headByte;
        end
    end

    // interrupt is a level while the count is at or above the programmed level
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= (bitCount >= CW'(irqLevel));
        end
    end

    // measurement cycle, twice as long in fine mode
    assign measLimit = fineMeasure ? MW'(2 * MEAS_LEN - 1) : MW'(MEAS_LEN - 1);
    always_ff @(posedge mclk) begin
        if (srst || !calcEnable) begin
            measCnt_r <= '0;
            measDone_r <= 1'b0;
            vdiAll_r <= 1'b1;
        end else if (measCnt_r >= measLimit) begin
            measCnt_r <= '0;
            measDone_r <= 1'b1;
            vdiAll_r <= 1'b1;
        end else begin
            measCnt_r <= measCnt_r + MW'(1);
            measDone_r <= 1'b0;
            vdiAll_r <= vdiAll_r && validDataFlag;
        end
    end

    // result capture at the end of each cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            latestErr_r <= '0;
            sameTwice_r <= 1'b0;
            vdiWhole_r <= 1'b0;
        end else if (calcEnable && measCnt_r >= measLimit) begin
            latestErr_r <= freqError;
            sameTwice_r <= (freqError == latestErr_r);
            vdiWhole_r <= vdiAll_r && validDataFlag;
        end
    end

    // completion toggle lets a polling host pace manual strobes
    always_ff @(posedge mclk) begin
        if (srst) begin
            measureToggle <= 1'b0;
        end else if (measDone_r) begin
            measureToggle <= ~measureToggle;
        end
    end

    assign autoOk = measDone_r && vdiWhole_r && sameTwice_r;

    // offset register; dropping on valid-data loss beats a same-cycle update
    always_ff @(posedge mclk) begin
        if (srst) begin
            offset_r <= '0;
            onceDone_r <= 1'b0;
            strobePrev_r <= 1'b0;
        end else begin
            strobePrev_r <= strobe;
            if (mode == MODE_DROP && vdiPrev_r && !validDataFlag) begin
                offset_r <= '0;
            end else begin
                case (mode)
                    MODE_MANUAL: begin
                        if (strobe && !strobePrev_r) begin
                            offset_r <= clampOfs(latestErr_r, rangeSel);
                        end
                    end
                    MODE_ONCE: begin
                        if (autoOk && !onceDone_r) begin
                            offset_r <= clampOfs(latestErr_r, rangeSel);
                            onceDone_r <= 1'b1;
                        end
                    end
                    default: begin
                        if (autoOk) begin
                            offset_r <= clampOfs(latestErr_r, rangeSel);
                        end
                    end
                endcase
            end
        end
    end

    // word added to the synthesizer control word
    always_ff @(posedge mclk) begin
        if (srst) begin
            offsetWord <= '0;
        end else begin
            offsetWord <= ofsEnable ? offset_r : '0;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    property p_fifo_cmd;
        newWord && lnk.cmdWord[15:8] == CMD_FIFO |=> fifoCfg_r == $past(lnk.cmdWord);
    endproperty
    a_fifo_cmd: assert property (p_fifo_cmd) else $error("fifo config not loaded");

    property p_irq_level;
        bitCount >= CW'(irqLevel) |=> irqRequest;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt missed at level");

    property p_sync_start;
        rxBitValid && syncMatch && fillEnable && !fillActive_r |=> fillActive_r;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("fill not started on sync");

    property p_fill_stop;
        !fillEnable |=> !fillActive_r;
    endproperty
    a_fill_stop: assert property (p_fill_stop) else $error("fill continued when disabled");

    property p_sync_cmd;
        newWord && lnk.cmdWord[15:8] == CMD_SYNC |=> syncCfg_r[7:0] == $past(lnk.cmdWord[7:0]);
    endproperty
    a_sync_cmd: assert property (p_sync_cmd) else $error("sync byte not loaded");

    property p_strobe;
        mode == MODE_MANUAL && strobe && !strobePrev_r
            |=> offset_r == clampOfs($past(latestErr_r), $past(rangeSel));
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe did not copy error");

    property p_ofs_gate;
        !ofsEnable |=> offsetWord == '0;
    endproperty
    a_ofs_gate: assert property (p_ofs_gate) else $error("offset leaked while disabled");

    property p_toggle;
        measDone_r |=> measureToggle != $past(measureToggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed a cycle end");

    property p_drop;
        mode == MODE_DROP && vdiPrev_r && !validDataFlag |=> offset_r == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("offset kept after valid-data fell");

    property p_no_calc;
        !calcEnable |=> !measDone_r [*2];
    endproperty
    a_no_calc: assert property (p_no_calc) else $error("measurement ran while disabled");
endmodule // rfa_rx_sync_afc_ctrl

// ===== testbench/rfa_host_model.sv
// host controller model driving the serial command link
`timescale 1ns/1ps
module rfa_host_model (
    // link clock, frame and data
    output logic sck,
    output logic csN,
    output logic sdi,
    input wire logic sdo
);
    // link clock stands still low between frames
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end
    // one frame, msb first; read byte taken on rising edges 9 to 16
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            #15 sck = 1'b1;
            if (i < 8) rd[i] = sdo;
            #15 sck = 1'b0;
        end
        #15 csN = 1'b1;
        sdi = ~sdi; // idle data line must not look like the last bit
    endtask
endmodule // rfa_host_model

// ===== testbench/rfa_rx_sync_afc_ctrl_bench.sv
// self-checking bench: host frames and receive bits in, flags and offset checked
`timescale 1ns/1ps
module rfa_rx_sync_afc_ctrl_bench;
    import rfa_pkg::*;
    localparam int ML = 4;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic rxBit = 1'b0;
    logic rxBitValid = 1'b0;
    logic dataQualityFlag = 1'b0;
    logic rssiFlag = 1'b0;
    logic crLockFlag = 1'b0;
    logic queueEnable = 1'b1;
    logic [1:0] vdiResponse = 2'h3;
    logic signed [OFS_W-1:0] freqError = 8'sh00;
    logic signed [OFS_W-1:0] offsetWord;
    logic sck, csN, sdi, sdo, irqRequest, validDataFlag, measureToggle;
    logic resetSensitivityOff, fineMeasure, tgl;
    logic [7:0] rd;
    logic [7:0] lim [4] = '{8'h9C, 8'hF0, 8'hF8, 8'hFC};
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    // 50 MHz system clock
    always #10 mclk = ~mclk;
    rfa_host_model i_host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo));
    rfa_rx_sync_afc_ctrl #(.MEAS_LEN(ML), .DEPTH(16)) i_dut (
        .mclk(mclk), .srst(srst), .sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo),
        .rxBit(rxBit), .rxBitValid(rxBitValid), .dataQualityFlag(dataQualityFlag),
        .rssiFlag(rssiFlag), .crLockFlag(crLockFlag), .vdiResponse(vdiResponse),
        .queueEnable(queueEnable), .freqError(freqError), .irqRequest(irqRequest),
        .validDataFlag(validDataFlag), .measureToggle(measureToggle),
        .resetSensitivityOff(resetSensitivityOff), .fineMeasure(fineMeasure),
        .offsetWord(offsetWord));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // a frame plus time for the core to pick the word up
    task automatic cmd(input logic [15:0] w);
        i_host.xfer(w, rd);
        wt(10);
    endtask
    // receive bits msb first, one every other cycle
    task automatic rxByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            #1 rxBit = b[i];
            rxBitValid = 1'b1;
            @(posedge mclk);
            #1 rxBitValid = 1'b0;
        end
        wt(3);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        wt(6);
        srst = 1'b0;
        wt(4);
        chk("irq", 1'b0, irqRequest);
        chk("sensOff", 1'b0, resetSensitivityOff);
        chk("fine", 1'b1, fineMeasure);
        chk("offset", 8'h00, offsetWord);
        // short sync, level 8
        cmd(16'hCA8A);
        rxByte(8'h55);
        rxByte(8'hD4);
        chk("irqEarly", 1'b0, irqRequest);
        rxByte(8'hA5);
        chk("irqLevel", 1'b1, irqRequest);
        cmd(16'hB000);
        chk("byte1", 8'hA5, rd);
        chk("irqDrain", 1'b0, irqRequest);
        // two-byte sync after a restart of the search
        cmd(16'hCA80);
        cmd(16'hCA82);
        rxByte(8'hD4);
        rxByte(8'h3C);
        chk("irqShort", 1'b0, irqRequest);
        rxByte(8'h2D);
        rxByte(8'hD4);
        rxByte(8'h3C);
        rxByte(8'hC3);
        cmd(16'hB000);
        chk("byte2", 8'h3C, rd);
        cmd(16'hB000);
        chk("byte3", 8'hC3, rd);
        // new low sync byte, high byte stays
        cmd(16'hCE96);
        cmd(16'hCA80);
        cmd(16'hCA82);
        rxByte(8'h2D);
        rxByte(8'hD4);
        rxByte(8'h5A);
        chk("oldSync", 1'b0, irqRequest);
        rxByte(8'h2D);
        rxByte(8'h96);
        rxByte(8'h5A);
        cmd(16'hB000);
        chk("byte4", 8'h5A, rd);
        // fill always, fill off, read refused
        cmd(16'hCA87);
        chk("sensOff", 1'b1, resetSensitivityOff);
        rxByte(8'h81);
        cmd(16'hB000);
        chk("byte5", 8'h81, rd);
        cmd(16'hCA84);
        rxByte(8'h81);
        chk("fillOff", 1'b0, irqRequest);
        cmd(16'hCA86);
        rxByte(8'h7E);
        queueEnable = 1'b0;
        cmd(16'hB000);
        chk("noPop", 1'b1, irqRequest);
        queueEnable = 1'b1;
        cmd(16'hB000);
        chk("byte6", 8'h7E, rd);
        // manual strobe across every range
        freqError = 8'sh9C;
        for (int r = 0; r < 4; r++) begin
            cmd(16'hC403 | 16'(r << 4));
            cmd(16'hC40B | 16'(r << 4));
            chk("clampLo", lim[r], offsetWord);
        end
        freqError = 8'sh40;
        cmd(16'hC433);
        cmd(16'hC43B);
        chk("clampHi", 8'h03, offsetWord);
        chk("fine", 1'b0, fineMeasure);
        cmd(16'hC409);
        chk("ofsOff", 8'h00, offsetWord);
        cmd(16'hC401);
        tgl = measureToggle;
        for (int n = 0; n < 4 * ML && measureToggle === tgl; n++) wt(1);
        chk("toggle", !tgl, measureToggle);
        cmd(16'hC400);
        tgl = measureToggle;
        wt(6 * ML);
        chk("calcOff", tgl, measureToggle);
        // keep mode, then drop mode on valid data
        freqError = 8'sh05;
        cmd(16'hC4C3);
        wt(8 * ML);
        chk("keep", 8'h05, offsetWord);
        vdiResponse = 2'h0;
        dataQualityFlag = 1'b1;
        freqError = 8'sh06;
        cmd(16'hC483);
        wt(8 * ML);
        chk("drop", 8'h06, offsetWord);
        chk("vdiFast", 1'b1, validDataFlag);
        dataQualityFlag = 1'b0;
        wt(3);
        chk("vdiLow", 1'b0, validDataFlag);
        chk("dropped", 8'h00, offsetWord);
        vdiResponse = 2'h1;
        rssiFlag = 1'b1;
        wt(3);
        chk("vdiMed", 1'b0, validDataFlag);
        crLockFlag = 1'b1;
        wt(3);
        chk("vdiLock", 1'b1, validDataFlag);
        // slow response: all three needed to rise, all three gone to fall
        vdiResponse = 2'h2;
        dataQualityFlag = 1'b1;
        wt(3);
        dataQualityFlag = 1'b0;
        rssiFlag = 1'b0;
        wt(3);
        chk("vdiSlow", 1'b1, validDataFlag);
        crLockFlag = 1'b0;
        wt(3);
        chk("vdiSlowOff", 1'b0, validDataFlag);
        // single-shot mode takes one result, later results are ignored
        cmd(16'hC443);
        vdiResponse = 2'h3;
        freqError = 8'sh07;
        wt(8 * ML);
        chk("once", 8'h07, offsetWord);
        freqError = 8'sh09;
        wt(8 * ML);
        chk("onceHeld", 8'h07, offsetWord);
        end_sim();
    end
endmodule // rfa_rx_sync_afc_ctrl_bench
